// ==== design/idw_top.sv ====
// Eight-channel input front end: filters, wire-break flags, data latch.
// Assumes synchronous inputs, active-low strobes, and a one-cycle read pulse for the flags.
//
// Overview of operation
// R01 - Capture all eight channels together when latch or chip select asserts
// R02 - Channel on reads as 1, off reads as 0
// R03 - Bypassed channel is sampled and refreshed at 1 MHz
// R04 - Filtered channel samples and counts at 200 kHz
// R05 - Per-channel bypass bit selects raw or filtered data
// R06 - Eight selectable delays, 50 us to 20 ms, per channel
// R07 - Counter counts up on high input, down on low
// R08 - Counter saturates at both bounds, never wraps
// R09 - Output rises at upper bound, falls at zero
// R10 - Upper bound makes a step take exactly the selected delay
// R11 - Bounce lengthens delay by twice the time at old level
// R12 - Each channel has an individually enabled wire-break comparator
// R13 - Tripped enabled comparator sets sticky flag after filtering
// R14 - Flags stay set until read; a read clears all at once
// R15 - Wire-break path has fixed 20 ms filter
// R16 - Flag register input frozen while logic strobe or select is low
// R17 - Group flag is OR of flags, set until all cleared
// R18 - Monitor tied to 3.3 V rail disables supply faults
// R19 - Data latch transparent while field strobes high, frozen on fall
// R20 - Fault register read keeps group flag; flag read clears it
// R21 - Counter holds about 4000 counts for the 20 ms delay
// R22 - Wire-break condition must persist the full period; gaps restart
`timescale 1ns/1ps
module idw_top #(
	parameter int NUM_CH = 8,
	parameter int WB_TICKS = idw_pkg::WB_FILT_TICKS
) (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic [NUM_CH-1:0] FIELD_CHANNEL_INPUTS,
	input wire logic [NUM_CH-1:0] WIRE_BREAK_TRIP,
	input wire logic [NUM_CH-1:0] WIRE_BREAK_ENABLE,
	input wire logic [NUM_CH-1:0] FILTER_BYPASS_BIT,
	input wire logic [3*NUM_CH-1:0] FILTER_DELAY_SEL,
	input wire logic LOGIC_SIDE_LATCH_STROBE_N,
	input wire logic LOGIC_SIDE_CHIP_SELECT_N,
	input wire logic FIELD_SIDE_LATCH_STROBE_N,
	input wire logic FIELD_SIDE_CHIP_SELECT_N,
	input wire logic WIRE_BREAK_FLAG_READ,
	input wire logic FIRST_FAULT_READ,
	input wire logic EXTERNAL_SUPPLY_MONITOR_AT_3V3,
	input wire logic SUPPLY_MISSING_DETECT,
	input wire logic SUPPLY_LOW_DETECT,
	output logic [NUM_CH-1:0] CHANNEL_DATA,
	output logic [NUM_CH-1:0] LATCHED_DATA,
	output logic [NUM_CH-1:0] WIRE_BREAK_FLAG_REGISTER,
	output logic WIRE_BREAK_GROUP_FLAG,
	output logic FIELD_SUPPLY_MISSING_FAULT,
	output logic FIELD_SUPPLY_LOW_FAULT
);
	// ----------------------------------------
	// Sample tick generation
	// ----------------------------------------
	logic [7:0] raw_div;
	logic [9:0] filt_div;
	wire raw_tick = (raw_div == 8'(idw_pkg::RAW_TICK_CYC - 1));
	wire filt_tick = (filt_div == 10'(idw_pkg::FILT_TICK_CYC - 1));

	// Free-running dividers for the 1 MHz and 200 kHz ticks
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			raw_div <= 8'h00;
			filt_div <= 10'h000;
		end else begin
			raw_div <= raw_tick ? 8'h00 : raw_div + 8'h01; // see R03
			filt_div <= filt_tick ? 10'h000 : filt_div + 10'h001; // see R04
		end
	end

	// ----------------------------------------
	// Per-channel filters
	// ----------------------------------------
	logic [NUM_CH-1:0] raw_sample;
	logic [NUM_CH-1:0] filt_out;
	logic [NUM_CH-1:0] wb_event;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
			idw_chan_filter #(
				.WB_TICKS(WB_TICKS)
			) u_filt (
				.clk(CLK_SYS),
				.rst_b(RST_B),
				.filt_tick(filt_tick),
				.raw_in(FIELD_CHANNEL_INPUTS[ch]),
				.delay_sel(FILTER_DELAY_SEL[3*ch +: 3]), // see R06
				.wb_trip(WIRE_BREAK_TRIP[ch]),
				.wb_enable(WIRE_BREAK_ENABLE[ch]), // see R12
				.filt_out(filt_out[ch]),
				.wb_event(wb_event[ch])
			);
		end
	endgenerate

	// Raw sampling at 1 MHz for bypassed channels
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			raw_sample <= idw_pkg::DATA_RST;
		end else if (raw_tick) begin
			raw_sample <= FIELD_CHANNEL_INPUTS; // see R02 see R03
		end
	end

	// ----------------------------------------
	// Channel data and latches
	// ----------------------------------------
	wire [NUM_CH-1:0] next_data = (FILTER_BYPASS_BIT & raw_sample)
		| (~FILTER_BYPASS_BIT & filt_out); // see R05
	wire logic_open = LOGIC_SIDE_LATCH_STROBE_N && LOGIC_SIDE_CHIP_SELECT_N;
	wire field_open = FIELD_SIDE_LATCH_STROBE_N && FIELD_SIDE_CHIP_SELECT_N;
	logic [NUM_CH-1:0] wb_seen;
	wire [NUM_CH-1:0] wb_new = wb_event & ~wb_seen;
	wire [NUM_CH-1:0] next_flags = (WIRE_BREAK_FLAG_READ ? idw_pkg::WB_FLAG_RST
		: WIRE_BREAK_FLAG_REGISTER) | (logic_open ? wb_new : '0); // see R13 see R14 see R16

	// Data follows selection; latched copies freeze on strobe falls
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			CHANNEL_DATA <= idw_pkg::DATA_RST;
			LATCHED_DATA <= idw_pkg::DATA_RST;
		end else begin
			if (logic_open) begin
				CHANNEL_DATA <= next_data; // see R01
			end
			if (field_open) begin
				LATCHED_DATA <= next_data; // see R19
			end
		end
	end

	// ----------------------------------------
	// Wire-break flags and group flag
	// ----------------------------------------
	// Set wins over the read clear; events held back while frozen
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			WIRE_BREAK_FLAG_REGISTER <= idw_pkg::WB_FLAG_RST;
			WIRE_BREAK_GROUP_FLAG <= 1'b0;
			wb_seen <= '0;
		end else begin
			WIRE_BREAK_FLAG_REGISTER <= next_flags; // see R14
			WIRE_BREAK_GROUP_FLAG <= |next_flags; // see R17 see R20
			if (logic_open) begin
				wb_seen <= wb_event; // see R16
			end
		end
	end

	// ----------------------------------------
	// Supply faults
	// ----------------------------------------
	// Sticky until the first fault register is read; disabled at 3.3 V tie
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B || EXTERNAL_SUPPLY_MONITOR_AT_3V3) begin
			FIELD_SUPPLY_MISSING_FAULT <= 1'b0; // see R18
			FIELD_SUPPLY_LOW_FAULT <= 1'b0; // see R18
		end else begin
			FIELD_SUPPLY_MISSING_FAULT <= SUPPLY_MISSING_DETECT
				| (FIELD_SUPPLY_MISSING_FAULT & ~FIRST_FAULT_READ);
			FIELD_SUPPLY_LOW_FAULT <= SUPPLY_LOW_DETECT
				| (FIELD_SUPPLY_LOW_FAULT & ~FIRST_FAULT_READ);
		end
	end

	// Refuse channel counts that the fixed-width resets cannot serve
	if (NUM_CH != 8) begin : g_bad_ch
		$error("NUM_CH must be 8");
	end
endmodule

// ==== design/idw_pkg.sv ====
// Package for the eight-channel input filter and wire-break front end.
// Assumes a 200 MHz system clock; used by the top module and its channel filter.
package idw_pkg;
	// ----------------------------------------
	// Clock and tick rates
	// ----------------------------------------
	localparam int CLK_HZ = 200000000;
	localparam int RAW_RATE_HZ = 1000000;
	localparam int FILT_RATE_HZ = 200000;
	localparam int RAW_TICK_CYC = CLK_HZ / RAW_RATE_HZ;
	localparam int FILT_TICK_CYC = CLK_HZ / FILT_RATE_HZ;

	// ----------------------------------------
	// Filter delays in microseconds, per select code
	// ----------------------------------------
	localparam int DLY0_US = 50;
	localparam int DLY1_US = 100;
	localparam int DLY2_US = 400;
	localparam int DLY3_US = 800;
	localparam int DLY4_US = 1600;
	localparam int DLY5_US = 3200;
	localparam int DLY6_US = 12800;
	localparam int DLY7_US = 20000;
	localparam int FILT_TICK_NS = 1000000000 / FILT_RATE_HZ;
	localparam int CNT_W = 12;

	// ----------------------------------------
	// Wire-break fixed filter
	// ----------------------------------------
	localparam int WB_FILT_MS = 20;
	localparam int WB_FILT_TICKS = WB_FILT_MS * 1000000 / FILT_TICK_NS;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] WB_FLAG_RST = 8'h00;

	// Upper bound for a delay code: delay divided by tick period
	function automatic logic [CNT_W-1:0] upper_bound(input logic [2:0] sel);
		int us;
		case (sel)
			3'h0: us = DLY0_US;
			3'h1: us = DLY1_US;
			3'h2: us = DLY2_US;
			3'h3: us = DLY3_US;
			3'h4: us = DLY4_US;
			3'h5: us = DLY5_US;
			3'h6: us = DLY6_US;
			default: us = DLY7_US;
		endcase
		return CNT_W'(us * 1000 / FILT_TICK_NS);
	endfunction
endpackage

// ==== design/idw_chan_filter.sv ====
// One channel: saturating up-down glitch filter and wire-break persistence timer.
// Assumes sample ticks from the top module and inputs synchronous to CLK_SYS.
`timescale 1ns/1ps
module idw_chan_filter #(
	parameter int WB_TICKS = idw_pkg::WB_FILT_TICKS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic filt_tick,
	input wire logic raw_in,
	input wire logic [2:0] delay_sel,
	input wire logic wb_trip,
	input wire logic wb_enable,
	output logic filt_out,
	output logic wb_event
);
	// ----------------------------------------
	// Glitch filter
	// ----------------------------------------
	logic [idw_pkg::CNT_W-1:0] count;
	logic [15:0] wb_count;
	wire [idw_pkg::CNT_W-1:0] limit = idw_pkg::upper_bound(delay_sel); // see R10
	wire at_top = (count >= limit); // see R08
	wire at_zero = (count == '0);
	wire [idw_pkg::CNT_W-1:0] next_count = raw_in ? (at_top ? limit : count + 1'b1)
		: (at_zero ? count : count - 1'b1); // see R07 see R08 see R11
	wire wb_active = wb_enable && wb_trip;
	wire wb_done = (wb_count >= 16'(WB_TICKS));

	// Counter steps only on the 200 kHz tick
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			count <= '0;
			filt_out <= 1'b0;
		end else if (filt_tick) begin
			count <= next_count; // see R04 see R21
			if (next_count >= limit) begin
				filt_out <= 1'b1; // see R09
			end else if (next_count == '0) begin
				filt_out <= 1'b0; // see R09
			end
		end
	end

	// ----------------------------------------
	// Wire-break fixed filter
	// ----------------------------------------
	// Any gap in the condition restarts the timer
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wb_count <= '0;
			wb_event <= 1'b0;
		end else if (!wb_active) begin
			wb_count <= '0; // see R22
			wb_event <= 1'b0;
		end else if (filt_tick) begin
			if (!wb_done) begin
				wb_count <= wb_count + 16'h0001;
			end
			wb_event <= (wb_count + 16'h0001 >= 16'(WB_TICKS)); // see R15
		end
	end

	// Refuse timer lengths that the 16-bit counter cannot hold
	if (WB_TICKS < 1 || WB_TICKS > 65000) begin : g_bad_ticks
		$error("WB_TICKS out of range");
	end
endmodule

// ==== sim/idw_properties.sv ====
// Checker for the eight-channel filter and wire-break front end.
// Assumes it is bound to idw_top with eight channels.
`timescale 1ns/1ps
module idw_properties (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic [7:0] WIRE_BREAK_ENABLE,
	input wire logic [7:0] WIRE_BREAK_TRIP,
	input wire logic LOGIC_SIDE_LATCH_STROBE_N,
	input wire logic LOGIC_SIDE_CHIP_SELECT_N,
	input wire logic FIELD_SIDE_LATCH_STROBE_N,
	input wire logic FIELD_SIDE_CHIP_SELECT_N,
	input wire logic WIRE_BREAK_FLAG_READ,
	input wire logic FIRST_FAULT_READ,
	input wire logic EXTERNAL_SUPPLY_MONITOR_AT_3V3,
	input wire logic [7:0] CHANNEL_DATA,
	input wire logic [7:0] LATCHED_DATA,
	input wire logic [7:0] WIRE_BREAK_FLAG_REGISTER,
	input wire logic WIRE_BREAK_GROUP_FLAG,
	input wire logic FIELD_SUPPLY_MISSING_FAULT,
	input wire logic FIELD_SUPPLY_LOW_FAULT
);
	// ----------------------------------------
	// Freeze conditions
	// ----------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	wire logic lhold = !LOGIC_SIDE_LATCH_STROBE_N || !LOGIC_SIDE_CHIP_SELECT_N;
	wire logic fhold = !FIELD_SIDE_LATCH_STROBE_N || !FIELD_SIDE_CHIP_SELECT_N;
	wire logic [7:0] flg = WIRE_BREAK_FLAG_REGISTER;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_group_or: assert property (WIRE_BREAK_GROUP_FLAG == |flg)
		else $error("group flag differs from flag OR");
	chk_flag_hold: assert property (
		!WIRE_BREAK_FLAG_READ |=> (flg & $past(flg)) == $past(flg))
		else $error("flag fell without a read");
	chk_flag_clear: assert property (
		WIRE_BREAK_FLAG_READ |=> (flg & $past(flg)) == 8'h00)
		else $error("flag survived a read");
	chk_flag_cause: assert property (
		(flg & ~$past(flg) & ~$past(WIRE_BREAK_ENABLE & WIRE_BREAK_TRIP, 2)) == 8'h00)
		else $error("flag set without enabled trip");
	chk_group_keep: assert property (
		FIRST_FAULT_READ && !WIRE_BREAK_FLAG_READ && WIRE_BREAK_GROUP_FLAG
		|=> WIRE_BREAK_GROUP_FLAG)
		else $error("fault read cleared group flag");
	chk_data_freeze: assert property (lhold ##1 lhold |=> $stable(CHANNEL_DATA))
		else $error("channel data moved while held");
	chk_latch_freeze: assert property (fhold ##1 fhold |=> $stable(LATCHED_DATA))
		else $error("latched data moved while held");
	chk_supply_off: assert property (
		EXTERNAL_SUPPLY_MONITOR_AT_3V3 [*2]
		|-> !FIELD_SUPPLY_MISSING_FAULT && !FIELD_SUPPLY_LOW_FAULT)
		else $error("supply fault while monitor off");
	cover property (WIRE_BREAK_FLAG_READ && |flg);
	cover property ($rose(WIRE_BREAK_GROUP_FLAG));
	cover property (lhold ##1 lhold);
endmodule
bind idw_top idw_properties i_idw_properties (.*);

// ==== sim/idw_field_model.sv ====
// Field side: eight sensors with switch state and wiring per channel.
// Assumes the bench changes sensor state and wiring off the clock edge.
`timescale 1ns/1ps
module idw_field_model (
	input wire logic [7:0] sensor_on,
	input wire logic [7:0] wire_open,
	output logic [7:0] level,
	output logic [7:0] current_missing
);
	// Closed sensor reads 1; a broken wire carries no current
	assign level = sensor_on & ~wire_open;
	assign current_missing = wire_open;
endmodule

// ==== sim/idw_top_test.sv ====
// Self-checking bench for the eight-channel filter and wire-break front end.
// Assumes a short wire-break timer and filter ticks every 1000 clocks.
`timescale 1ns/1ps
module idw_top_test;
	logic clk = 0;
	logic rst_b = 0;
	logic [7:0] on = 0, wopen = 0, wb_en = 0, byp = 0, dq, fq, mdl = 0;
	logic lls_n = 1, lcs_n = 1, fls_n = 1, fcs_n = 1, wb_rd = 0, ff_rd = 0;
	logic ext = 1, sup = 1, slo = 0;
	logic [31:0] rs = 32'h61bd;
	wire logic [7:0] ins, trip, cdata, ldata, flags;
	wire logic grp, smiss, slow;
	int failures = 0, samples_checked = 0, cyc = 0, cnt[8], bnd[8];
	int us[8] = '{idw_pkg::DLY0_US, idw_pkg::DLY1_US, idw_pkg::DLY2_US, idw_pkg::DLY3_US,
		idw_pkg::DLY4_US, idw_pkg::DLY5_US, idw_pkg::DLY6_US, idw_pkg::DLY7_US};

	// Clock and cycle count since reset release
	always #2.5 clk = ~clk;
	always @(posedge clk) cyc <= rst_b ? cyc + 1 : 0;

	idw_field_model i_idw_field_model (.sensor_on(on), .wire_open(wopen), .level(ins),
		.current_missing(trip));
	idw_top #(.WB_TICKS(3)) i_idw_top (.CLK_SYS(clk), .RST_B(rst_b),
		.FIELD_CHANNEL_INPUTS(ins), .WIRE_BREAK_TRIP(trip), .WIRE_BREAK_ENABLE(wb_en),
		.FILTER_BYPASS_BIT(byp), .FILTER_DELAY_SEL(24'hfac688),
		.LOGIC_SIDE_LATCH_STROBE_N(lls_n), .LOGIC_SIDE_CHIP_SELECT_N(lcs_n),
		.FIELD_SIDE_LATCH_STROBE_N(fls_n), .FIELD_SIDE_CHIP_SELECT_N(fcs_n),
		.WIRE_BREAK_FLAG_READ(wb_rd), .FIRST_FAULT_READ(ff_rd),
		.EXTERNAL_SUPPLY_MONITOR_AT_3V3(ext), .SUPPLY_MISSING_DETECT(sup),
		.SUPPLY_LOW_DETECT(slo), .CHANNEL_DATA(cdata), .LATCHED_DATA(ldata),
		.WIRE_BREAK_FLAG_REGISTER(flags), .WIRE_BREAK_GROUP_FLAG(grp),
		.FIELD_SUPPLY_MISSING_FAULT(smiss), .FIELD_SUPPLY_LOW_FAULT(slow));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Wait for the point halfway between filter ticks
	task automatic mid;
		do @(negedge clk); while (cyc % 1000 != 500);
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#500000;
		failures++;
		tally_and_finish();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		foreach (bnd[n]) bnd[n] = us[n] * 1000 / idw_pkg::FILT_TICK_NS;
		repeat (5) @(negedge clk);
		rst_b = 1;
		// Filter with a tick-level counter model, bouncing rise then fall
		for (int j = 0; j < 74; j++) begin
			mid;
			check(cdata, mdl);
			rs = xs(rs);
			on = (j < 62) ? ~(rs[7:0] & rs[15:8] & rs[23:16] & 8'h03) : rs[7:0] & rs[15:8];
			foreach (cnt[n]) begin
				cnt[n] = on[n] ? ((cnt[n] < bnd[n]) ? cnt[n] + 1 : bnd[n])
					: ((cnt[n] > 0) ? cnt[n] - 1 : 0);
				if (cnt[n] == bnd[n]) mdl[n] = 1;
				if (cnt[n] == 0) mdl[n] = 0;
			end
		end
		// Raw path: logic hold alone, both held, then field hold alone
		byp = 8'hff;
		for (int i = 0; i < 4; i++) begin
			lcs_n = (i != 1);
			lls_n = (i != 2);
			fcs_n = (i != 2);
			fls_n = (i != 3);
			rs = xs(rs);
			on = rs[7:0];
			if (i == 0) dq = on;
			if (i == 1) fq = on;
			repeat (400) @(negedge clk);
			check(cdata, (i % 3) ? dq : on);
			check(ldata, (i < 2) ? on : fq);
		end
		fls_n = 1;
		// Wire-break timing, restart, hold-back while chip select low
		wb_en = 8'h0f;
		for (int j = 0; j < 10; j++) begin
			mid;
			check(flags, {6'h00, j >= 8, j >= 3});
			check({7'h00, grp}, {7'h00, j >= 3});
			wopen = (j == 2) ? 8'h31 : 8'h33;
			lcs_n = !(j inside {4, 5, 6});
		end
		ff_rd = 1;
		@(negedge clk);
		ff_rd = 0;
		@(negedge clk);
		check({7'h00, grp}, 8'h01);
		wb_rd = 1;
		@(negedge clk);
		wb_rd = 0;
		@(negedge clk);
		check(flags, 8'h00);
		check({7'h00, grp}, 8'h00);
		mid;
		mid;
		check(flags, 8'h00);
		check({6'h00, smiss, slow}, 8'h00);
		ext = 0;
		repeat (4) @(negedge clk);
		check({6'h00, smiss, slow}, 8'h02);
		sup = 0;
		slo = 1;
		repeat (2) @(negedge clk);
		check({6'h00, smiss, slow}, 8'h03);
		slo = 0;
		ff_rd = 1;
		@(negedge clk);
		ff_rd = 0;
		@(negedge clk);
		check({6'h00, smiss, slow}, 8'h00);
		tally_and_finish();
	end
endmodule
